// ### hdl/scaling_accumulator_regs.svh
// Purpose: register offsets, fields, reset values and limits of the
//          scaling accumulator.
// Assumes: byte addresses on a 32-bit Avalon-MM slave.
// Notes:   definitions only.
`ifndef SCALING_ACCUMULATOR_REGS_SVH
`define SCALING_ACCUMULATOR_REGS_SVH

// byte offsets of the register words
`define CTRL_OFFSET       4'h0
`define STATUS_OFFSET     4'h4
`define RESULT_OFFSET     4'h8
`define CONFIG_OFFSET     4'hC

// control word fields
`define CTRL_RUN_BIT      0
`define CTRL_CLEAR_BIT    1
`define CTRL_RESET        2'h1

// status word fields
`define STATUS_OVF_BIT    0
`define STATUS_RUN_BIT    1

// config word fields (read only)
`define CONFIG_SHIFT_LSB  0
`define CONFIG_SUB_BIT    4
`define CONFIG_SAT_BIT    5
`define CONFIG_RELOAD_BIT 6
`define CONFIG_RST_BIT    7

// limits of the build options
`define MAX_FB_SHIFT      8
`define MAX_EXTRA_MSB     54

`endif

// ### hdl/scaling_accumulator_pkg.sv
// Purpose: types shared by the scaling accumulator and its bench.
// Assumes: Avalon-MM with waitrequest, 32-bit data.
// Notes:   the request travels as one packed struct.
package scaling_accumulator_pkg;

  // one Avalon-MM request from the master
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  // bus answer sequencer, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

// ### hdl/scaling_accumulator.sv
// Purpose: fixed-point scaling accumulator with a small register slave.
// Assumes: all inputs but resetn synchronous to sys_clk; ce freezes every flop.
// Notes:   result q is registered; one cycle from b to q.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "scaling_accumulator_regs.svh"

module scaling_accumulator #(
  parameter int DATA_W        = 16, // sample and result width
  parameter int FRAC_W        = 8,  // binary point, carried through untouched
  parameter bit SIGNED_DATA   = 1,  // two's complement samples
  parameter bit SUBTRACT      = 0,  // subtractor-based accumulator
  parameter int FB_SHIFT      = 0,  // feedback factor is 2**-FB_SHIFT
  parameter bit HAS_RST       = 1,  // synchronous reset port in use
  parameter bit REINIT_FROM_B = 0,  // reset reloads from b
  parameter bit SATURATE      = 0,  // saturate (zero on unsigned add overflow), else wrap
  parameter int EXTRA_MSB     = 0   // internal bits above the input top bit
) (
  input  wire logic                              sys_clk,         // system clock
  input  wire logic                              resetn,          // async reset, low
  input  wire logic                              ce,              // clock enable
  input  wire logic                              rst,             // sync reset
  input  wire logic                              en,              // step enable
  input  wire logic [DATA_W-1:0]                 b,               // input sample
  output logic      [DATA_W-1:0]                 q,               // result
  output logic                                   q_ovf,           // last step overflowed
  input  wire scaling_accumulator_pkg::avmm_req_t avs_req,        // bus request
  output logic      [31:0]                       avs_readdata,    // bus read data
  output logic                                   avs_waitrequest  // bus stall
);
  import scaling_accumulator_pkg::*;

  // internal widths
  localparam int ACC_W = DATA_W + EXTRA_MSB;
  localparam int SUM_W = ACC_W + 1;
  localparam int RD_W  = (DATA_W < 32) ? DATA_W : 32;

  // reload exists only behind a reset port
  localparam bit RELOAD = HAS_RST && REINIT_FROM_B;

  // sign or zero extend a sample to the sum width
  function automatic logic [SUM_W-1:0] widen_in(
    input logic [DATA_W-1:0] v
  );
    logic [SUM_W-1:0] r;
    r = {SUM_W{1'b0}};
    for (int i = 0; i < SUM_W; i++) begin
      if (i < DATA_W) begin
        r[i] = v[i];
      end else begin
        r[i] = SIGNED_DATA ? v[DATA_W-1] : 1'b0;
      end
    end
    widen_in = r;
  endfunction

  // scaled feedback: shift right, keeping the sign for signed data
  function automatic logic [SUM_W-1:0] scale_fb(
    input logic [ACC_W-1:0] v
  );
    logic [SUM_W-1:0] r;
    logic             fill;
    r    = {SUM_W{1'b0}};
    fill = SIGNED_DATA ? v[ACC_W-1] : 1'b0;
    for (int i = 0; i < SUM_W; i++) begin
      if (i + FB_SHIFT < ACC_W) begin
        r[i] = v[i + FB_SHIFT];
      end else begin
        r[i] = fill;
      end
    end
    scale_fb = r;
  endfunction

  // largest value a field of the given width can hold, or the smallest when neg is set
  function automatic logic [ACC_W-1:0] top_value(
    input int w,
    input bit neg
  );
    logic [ACC_W-1:0] r;
    r = {ACC_W{1'b0}};
    for (int i = 0; i < ACC_W; i++) begin
      if (SIGNED_DATA) begin
        if (i < w - 1) begin
          r[i] = !neg;
        end else begin
          r[i] = neg;
        end
      end else begin
        r[i] = (i < w) && !neg;
      end
    end
    top_value = r;
  endfunction

  // does v fit in the low w bits of an ACC_W field
  function automatic bit fits(
    input logic [SUM_W-1:0] v,
    input int               w
  );
    bit ok;
    ok = 1'b1;
    for (int i = 0; i < SUM_W; i++) begin
      if (SIGNED_DATA) begin
        if (i >= w - 1 && v[i] != v[SUM_W-1]) begin
          ok = 1'b0;
        end
      end else if (i >= w && v[i]) begin
        ok = 1'b0;
      end
    end
    fits = ok;
  endfunction

  // clip or wrap a value into the low w bits of an ACC_W field
  function automatic logic [ACC_W-1:0] fit_to(
    input logic [SUM_W-1:0] v,
    input int               w
  );
    logic [ACC_W-1:0] r;
    r = v[ACC_W-1:0];
    if (!fits(v, w) && SATURATE) begin
      r = top_value(w, v[SUM_W-1]);
    end else begin
      for (int i = 0; i < ACC_W; i++) begin
        if (i >= w) begin
          r[i] = SIGNED_DATA ? v[w-1] : 1'b0;
        end
      end
    end
    fit_to = r;
  endfunction

  // state
  logic [ACC_W-1:0] acc;
  logic             run;
  logic             sticky_ovf;
  bus_state_t       bus_state;

  // next values
  logic [ACC_W-1:0]  next_acc;
  logic [DATA_W-1:0] next_q;
  logic              next_q_ovf;
  logic              next_run;
  logic              next_sticky;
  bus_state_t        next_bus_state;
  logic [31:0]       next_readdata;
  logic              next_waitrequest;

  // extend the stored word by one bit for the narrowing check
  function automatic logic [SUM_W-1:0] widen_acc(
    input logic [ACC_W-1:0] v
  );
    widen_acc = {SIGNED_DATA ? v[ACC_W-1] : 1'b0, v};
  endfunction

  // datapath terms
  wire logic [SUM_W-1:0] in_wide   = widen_in(b);
  wire logic [SUM_W-1:0] fb_wide   = scale_fb(acc);
  wire logic [SUM_W-1:0] sum_add   = fb_wide + in_wide;
  wire logic [SUM_W-1:0] sum_sub   = fb_wide - in_wide;
  wire logic [SUM_W-1:0] sum       = SUBTRACT ? sum_sub : sum_add;
  wire logic [ACC_W-1:0] sum_fit   = fit_to(sum, ACC_W);
  wire logic             sum_ovf   = !fits(sum, ACC_W);
  wire logic [SUM_W-1:0] fit_wide  = widen_acc(sum_fit);
  wire logic             out_ovf   = !fits(fit_wide, DATA_W);
  wire logic [ACC_W-1:0] load_val  = RELOAD ? in_wide[ACC_W-1:0] : {ACC_W{1'b0}};

  // bus decode
  wire logic       bus_req    = avs_req.read || avs_req.write;
  wire logic       bus_take   = (bus_state == BUS_ANSWER) && avs_req.write;
  wire logic [3:0] word_addr  = {avs_req.address[3:2], 2'b00};
  wire logic       hit_ctrl   = word_addr == `CTRL_OFFSET;
  wire logic       hit_status = word_addr == `STATUS_OFFSET;
  wire logic       hit_result = word_addr == `RESULT_OFFSET;
  wire logic       hit_config = word_addr == `CONFIG_OFFSET;
  wire logic       wr_lane0   = bus_take && avs_req.byteenable[0];
  wire logic       wr_ctrl    = wr_lane0 && hit_ctrl;
  wire logic       wr_status  = wr_lane0 && hit_status;

  // software clear is a pulse, never stored
  wire logic soft_clear = wr_ctrl && avs_req.writedata[`CTRL_CLEAR_BIT];
  wire logic ovf_w1c    = wr_status && avs_req.writedata[`STATUS_OVF_BIT];

  // reset wins over enable; reload only from the rst port
  wire logic hw_clear   = HAS_RST && rst;
  wire logic step       = en && run;

  // accumulator update; holding while disabled keeps the value
  always_comb begin
    if (hw_clear) begin
      next_acc   = load_val;
      next_q_ovf = 1'b0;
    end else if (soft_clear) begin
      next_acc   = {ACC_W{1'b0}};
      next_q_ovf = 1'b0;
    end else if (step) begin
      next_acc   = sum_fit;
      next_q_ovf = sum_ovf || out_ovf;
    end else begin
      next_acc   = acc;
      next_q_ovf = q_ovf;
    end
  end

  // output word: same width, type and binary point as b
  wire logic [ACC_W-1:0] q_fit = fit_to(widen_acc(next_acc), DATA_W);
  assign next_q = q_fit[DATA_W-1:0];

  // a new overflow beats a clear in the same cycle
  assign next_sticky = (step && !hw_clear && !soft_clear && (sum_ovf || out_ovf))
                       || (sticky_ovf && !ovf_w1c);

  assign next_run = wr_ctrl ? avs_req.writedata[`CTRL_RUN_BIT] : run;

  // read mux; unmapped words read zero
  logic [31:0] rd_result;
  logic [31:0] rd_config;
  always_comb begin
    rd_result = 32'h0000_0000;
    rd_result[RD_W-1:0] = q[RD_W-1:0];
    rd_config = 32'h0000_0000;
    rd_config[`CONFIG_SHIFT_LSB +: 4] = 4'(FB_SHIFT);
    rd_config[`CONFIG_SUB_BIT]        = SUBTRACT;
    rd_config[`CONFIG_SAT_BIT]        = SATURATE;
    rd_config[`CONFIG_RELOAD_BIT]     = RELOAD;
    rd_config[`CONFIG_RST_BIT]        = HAS_RST;
  end

  wire logic [31:0] rd_ctrl   = {31'h0000_0000, run};
  wire logic [31:0] rd_status = {30'h0000_0000, run, sticky_ovf};
  wire logic [31:0] rd_word   = hit_ctrl   ? rd_ctrl   :
                                hit_status ? rd_status :
                                hit_result ? rd_result :
                                hit_config ? rd_config : 32'h0000_0000;

  // bus sequencer: one stall cycle, then one answer cycle
  always_comb begin
    next_bus_state   = bus_state;
    next_readdata    = avs_readdata;
    next_waitrequest = avs_waitrequest;
    case (bus_state)
      BUS_IDLE: begin
        if (bus_req) begin
          next_bus_state   = BUS_ANSWER;
          next_readdata    = rd_word;
          next_waitrequest = 1'b0;
        end
      end
      BUS_ANSWER: begin
        next_bus_state   = BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_bus_state   = BUS_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  // datapath flops; the rst reload waits on ce, the resetn load does not
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc   <= {ACC_W{1'b0}};
      q     <= {DATA_W{1'b0}};
      q_ovf <= 1'b0;
    end else if (ce) begin
      acc   <= next_acc;
      q     <= next_q;
      q_ovf <= next_q_ovf;
    end
  end

  // register and bus flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run             <= 1'b1;
      sticky_ovf      <= 1'b0;
      bus_state       <= BUS_IDLE;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      run             <= next_run;
      sticky_ovf      <= next_sticky;
      bus_state       <= next_bus_state;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

endmodule

// ### sim/scaling_accumulator_properties.sv
// Purpose: port checks of the scaling accumulator.
// Assumes: signed wrap build, one clock domain.
// Notes:   bound to the top module below.
`timescale 1ns/10ps
module accum_properties #(
  parameter int DATA_W        = 16, // sample width
  parameter int FB_SHIFT      = 0,  // feedback shift
  parameter bit REINIT_FROM_B = 0   // reset reloads from b
) (
  input wire logic                               sys_clk,        // clock
  input wire logic                               resetn,         // async reset, low
  input wire logic                               ce,             // clock enable
  input wire logic                               rst,            // sync reset
  input wire logic                               en,             // step enable
  input wire logic [DATA_W-1:0]                  b,              // sample
  input wire logic [DATA_W-1:0]                  q,              // result
  input wire logic                               q_ovf,          // overflow
  input wire scaling_accumulator_pkg::avmm_req_t avs_req,        // bus request
  input wire logic                               avs_waitrequest // bus stall
);
  import scaling_accumulator_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire req = avs_req.read || avs_req.write;
  // software clear strobe in the answer cycle; it beats a step or a hold
  wire clr = avs_req.write && !avs_waitrequest && avs_req.address[3:2] == 2'h0 &&
             avs_req.byteenable[0] && avs_req.writedata[1];

  // one wrapped step; run may be off, so a hold is also accepted
  function automatic logic [DATA_W-1:0] nxt(input logic [DATA_W-1:0] a,
                                            input logic [DATA_W-1:0] d);
    logic signed [DATA_W-1:0] s;
    s = $signed(a) >>> FB_SHIFT;
    return s + d;
  endfunction

  property p_reload; ce && rst && REINIT_FROM_B |=> q == $past(b); endproperty
  a_reload: assert property (p_reload) else $error("reset did not reload");
  property p_step; ce && !rst && !clr && en |=> q == nxt($past(q), $past(b)) || $stable(q);
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_hold; ce && !rst && !clr && !en |=> $stable(q); endproperty
  a_hold: assert property (p_hold) else $error("q moved with en low");
  property p_freeze; !ce |=> $stable(q) && $stable(q_ovf); endproperty
  a_freeze: assert property (p_freeze) else $error("q moved with ce low");
  property p_rst_ovf; ce && rst |=> !q_ovf; endproperty
  a_rst_ovf: assert property (p_rst_ovf) else $error("reset left overflow");
  property p_clear; ce && !rst && clr |=> q == '0 && !q_ovf; endproperty
  a_clear: assert property (p_clear) else $error("software clear did not zero q");
  property p_wait_one; ce && !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  property p_answer; ce && req && avs_waitrequest |-> ##[1:2] !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_idle; ce && !req && avs_waitrequest |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  c_reload: cover property (ce && rst);
  c_step: cover property (ce && en && !rst);
  c_read: cover property (avs_req.read && !avs_waitrequest);
endmodule
bind scaling_accumulator accum_properties #(.DATA_W(DATA_W), .FB_SHIFT(FB_SHIFT),
  .REINIT_FROM_B(REINIT_FROM_B)) chk (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
  .rst(rst), .en(en), .b(b), .q(q), .q_ovf(q_ovf), .avs_req(avs_req),
  .avs_waitrequest(avs_waitrequest));

// ### sim/stream_partner.sv
// Purpose: upstream sample source beside the accumulator.
// Assumes: mode 0 quiet, 1 stream, 2 stream with ce gaps.
// Notes:   ce stays high outside mode 2 so bus cycles are not frozen.
`timescale 1ns/10ps
module stream_partner (
  input  wire logic       sys_clk, // clock
  input  wire logic [1:0] mode,    // traffic mode
  output logic            ce,      // clock enable
  output logic            rst,     // sync reset
  output logic            en,      // step enable
  output logic [15:0]     b        // sample
);
  integer seed = 32'h8A10B869;
  initial {ce, rst, en, b} = {3'b100, 16'h0000};

  // rst is a one-bit boolean at the clock rate, rare enough to let sums grow
  always @(posedge sys_clk) begin
    b   <= 16'($random(seed));
    en  <= (mode != 2'h0) && ($random(seed) % 4 != 0);
    rst <= (mode != 2'h0) && ($random(seed) % 16 == 0);
    ce  <= (mode != 2'h2) || ($random(seed) % 4 != 0);
  end
endmodule

// ### sim/scaling_accumulator_test.sv
// Purpose: self-checking bench of the scaling accumulator.
// Assumes: shift 2, reload on reset, wrap, 16-bit signed.
// Notes:   an integer model is compared with q every cycle.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module scaling_accumulator_test;
  import scaling_accumulator_pkg::*;
  localparam int S = 2;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        ce, rst, en, q_ovf, avs_waitrequest;
  logic [15:0] b, q;
  logic [31:0] avs_readdata, rd;
  logic [1:0]  mode    = 2'h0;
  avmm_req_t   avs_req = '0;
  int          fails = 0, samples_checked = 0, cycles = 0;
  int          m_q = 0, m_run = 1, m_ovf = 0, m_stk = 0, sum;
  // write seen in its answer cycle on lane 0
  wire         wr_ok = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];

  scaling_accumulator #(.FB_SHIFT(S), .REINIT_FROM_B(1'b1)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .ce(ce), .rst(rst), .en(en), .b(b), .q(q), .q_ovf(q_ovf),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  stream_partner src (.sys_clk(sys_clk), .mode(mode), .ce(ce), .rst(rst), .en(en), .b(b));

  initial forever #10 sys_clk = ~sys_clk;

  // model sees the pre-edge values; the run bit changes after the step
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      m_q = 0; m_run = 1; m_ovf = 0; m_stk = 0;
    end else if (ce) begin
      sum = (m_q >>> S) + $signed(b);
      if (wr_ok && avs_req.address[3:2] == 2'h1 && avs_req.writedata[0]) m_stk = 0;
      if (rst) begin
        m_q = $signed(b); m_ovf = 0;
      end else if (wr_ok && avs_req.address[3:2] == 2'h0 && avs_req.writedata[1]) begin
        m_q = 0; m_ovf = 0;
      end else if (en && m_run) begin
        m_q = $signed(sum[15:0]); m_ovf = (sum > 32767 || sum < -32768);
        if (m_ovf) m_stk = 1;
      end
      if (wr_ok && avs_req.address[3:2] == 2'h0) m_run = avs_req.writedata[0];
    end
  end

  // compare away from the edge so both sides have settled
  always @(negedge sys_clk) if (resetn) begin
    `CHK("q", 16'(m_q), q)
    `CHK("q_ovf", 1'(m_ovf), q_ovf)
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end

  // one Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: be};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_req <= '0;
  endtask

  task automatic close_out();
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    bus(0, 4'hD, 0, 4'hF);
    `CHK("config", 32'h000000C2, rd)
    bus(0, 4'h0, 0, 4'hF);
    `CHK("ctrl", 32'h00000001, rd)
    mode <= 2'h1;
    repeat (300) @(posedge sys_clk);
    bus(1, 4'h0, 0, 4'h0); // no byte lane, so run stays on
    bus(1, 4'h8, 32'h00005A5A, 4'hF); // result word is read only
    bus(1, 4'h0, 0, 4'hF);
    repeat (50) @(posedge sys_clk);
    mode <= 2'h0;
    bus(0, 4'h4, 0, 4'hF);
    `CHK("run", 1'b0, rd[1])
    `CHK("sticky", 1'(m_stk), rd[0])
    bus(1, 4'h4, 1, 4'hF); // sticky is write-one-to-clear
    bus(0, 4'h4, 0, 4'hF);
    `CHK("status", 32'h00000000, rd)
    bus(0, 4'h8, 0, 4'hF);
    `CHK("result", {16'h0000, 16'(m_q)}, rd)
    bus(1, 4'h0, 32'h00000003, 4'hF); // run on and one-shot clear
    bus(0, 4'h8, 0, 4'hF);
    `CHK("cleared", 32'h00000000, rd)
    bus(1, 4'h0, 1, 4'hF);
    mode <= 2'h2;
    repeat (400) @(posedge sys_clk);
    mode <= 2'h1;
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (100) @(posedge sys_clk);
    close_out();
  end
endmodule
